// ### dv/sram_model.sv
// behavioural static memory with correction flag, seen only through its pins
`timescale 1ns/1ps
module sram_model (
  input  wire logic                core_clk,
  input  wire logic                wide_mode,
  input  wire logic [19:0]         mem_addr,
  input  wire logic                mem_byte_addr,
  input  wire sram_host_pkg::ctl_s mem_ctl,
  input  wire logic [15:0]         mem_data_out,
  input  wire logic [1:0]          mem_data_oe,
  input  wire logic [20:0]         err_key,
  input  wire logic [3:0]          lat,
  output logic [15:0]              mem_data_in,
  output logic                     mem_err_in,
  output int                       viol
);
  localparam int PW = (sram_host_pkg::T_HZWE_NS + sram_host_pkg::T_SD_NS + 3) / 4;
  localparam int SD = (sram_host_pkg::T_SD_NS + 3) / 4;
  logic [15:0] arr [int];
  logic [15:0] wd, rd;
  logic [19:0] addr_q;
  logic [1:0]  ln;
  logic        sel, act, drv, act_q, sel_q, bad;
  int          key, wcnt, rcnt, dcnt;
  initial begin
    {wd, addr_q, act_q, sel_q, mem_data_in, mem_err_in} = '0;
    {viol, wcnt, rcnt, dcnt} = '0;
  end
  // pin decode: narrow mode uses only the low lane
  assign ln  = wide_mode ? ~{mem_ctl.upper_lane_enable_n, mem_ctl.lower_lane_enable_n} : 2'b01;
  assign sel = !mem_ctl.first_select_n && mem_ctl.second_select_high && (ln != 2'b00);
  assign act = sel && !mem_ctl.write_strobe_n;
  assign drv = sel && mem_ctl.write_strobe_n && !mem_ctl.output_enable_n;
  assign key = wide_mode ? int'(mem_addr) : int'({mem_addr, mem_byte_addr});
  // a write end needs data still driven, unchanged, set up long enough, and a wide enough strobe
  assign bad = (act_q && !act && (mem_data_out !== wd || (mem_data_oe & ln) !== ln || wcnt < PW || dcnt < SD))
               || (drv && mem_data_oe != 2'b00) || (act && !mem_ctl.output_enable_n)
               || (sel && sel_q && mem_addr != addr_q);
  // write on overlap, commit on the terminating edge, drive reads after lat cycles
  always @(posedge core_clk) begin
    rd = arr.exists(key) ? arr[key] : 16'h0000;
    if (bad) viol <= viol + 1;
    if (act) begin
      wcnt <= wcnt + 1;
      if ((mem_data_oe & ln) == ln) begin
        wd <= mem_data_out;
        dcnt <= dcnt + 1;
      end
    end
    if (act_q && !act) begin
      if (ln[0]) rd[7:0] = wd[7:0];
      if (ln[1]) rd[15:8] = wd[15:8];
      arr[key] = rd;
      wcnt <= 0;
      dcnt <= 0;
    end
    rcnt <= drv ? rcnt + 1 : 0;
    if (drv && rcnt >= int'(lat)) begin
      mem_data_in <= {ln[1] ? rd[15:8] : ~mem_data_in[15:8], ln[0] ? rd[7:0] : ~mem_data_in[7:0]};
      mem_err_in <= (key == int'(err_key));
    end else begin
      mem_data_in <= ~mem_data_in;
      mem_err_in <= ~mem_err_in;
    end
    act_q <= act;
    sel_q <= sel;
    addr_q <= mem_addr;
  end
endmodule

// ### dv/tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb;
  logic core_clk, rst_n, wide_mode, req_valid, req_ready, rsp_valid, mem_byte_addr, mem_err_in;
  sram_host_pkg::req_s req;
  sram_host_pkg::rsp_s rsp;
  sram_host_pkg::ctl_s mem_ctl;
  logic [19:0]         mem_addr;
  logic [15:0]         mem_data_in, mem_data_out;
  logic [1:0]          mem_data_oe;
  logic [20:0]         err_key;
  logic [3:0]          lat;
  int                  fail_count, checked, cyc, viol;
  sram_host dut (.core_clk(core_clk), .rst_n(rst_n), .wide_mode(wide_mode), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .mem_addr(mem_addr),
    .mem_byte_addr(mem_byte_addr), .mem_ctl(mem_ctl), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_err_in(mem_err_in));
  sram_model mem (.core_clk(core_clk), .wide_mode(wide_mode), .mem_addr(mem_addr),
    .mem_byte_addr(mem_byte_addr), .mem_ctl(mem_ctl), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .err_key(err_key), .lat(lat), .mem_data_in(mem_data_in),
    .mem_err_in(mem_err_in), .viol(viol));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp16(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  // one request; reads check the answer delay of 14 cycles
  task automatic xfer(input logic wr, input logic [20:0] a, input logic [15:0] d, input logic [1:0] ln);
    int n;
    @(negedge core_clk);
    req = '{wr, a, d, ln};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    if (!wr) cmp16("read delay", 16'h000E, 16'(n));
    while (req_ready !== 1'b1 && n < 80) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic do_reset(input logic wide);
    rst_n = 1'b0;
    wide_mode = wide;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_wide();
    xfer(1'b1, 21'h01234, 16'hA55A, 2'b11);
    xfer(0, 21'h01234, 16'h0000, 2'b11);
    cmp16("word", 16'hA55A, rsp.rdata);
    cmp1("flag clean", 1'b0, rsp.corrected);
  endtask
  task automatic t_lanes();
    xfer(1'b1, 21'h0ABCD, 16'h1234, 2'b11);
    xfer(1'b1, 21'h0ABCD, 16'hABCD, 2'b10);
    xfer(0, 21'h0ABCD, 16'h0000, 2'b11);
    cmp16("upper write", 16'hAB34, rsp.rdata);
    xfer(0, 21'h0ABCD, 16'h0000, 2'b01);
    cmp16("lower read", 16'h0034, rsp.rdata);
  endtask
  task automatic t_err();
    err_key = 21'h0ABCD;
    lat = 4'h8;
    xfer(0, 21'h0ABCD, 16'h0000, 2'b11);
    cmp16("slow word", 16'hAB34, rsp.rdata);
    cmp1("flag set", 1'b1, rsp.corrected);
    lat = 4'h0;
    xfer(0, 21'h01234, 16'h0000, 2'b11);
    cmp1("flag clear", 1'b0, rsp.corrected);
  endtask
  task automatic t_nolane();
    @(negedge core_clk);
    req = '{1'b1, 21'h00055, 16'hFFFF, 2'b00};
    req_valid = 1'b1;
    repeat (4) @(negedge core_clk);
    cmp1("ready kept", 1'b1, req_ready);
    cmp1("still idle", 1'b1, mem_ctl.first_select_n);
    req_valid = 1'b0;
  endtask
  task automatic t_narrow();
    do_reset(1'b0);
    xfer(1'b1, 21'h00101, 16'h00C3, 2'b00);
    xfer(1'b1, 21'h00100, 16'h003C, 2'b00);
    xfer(0, 21'h00101, 16'h0000, 2'b00);
    cmp16("odd byte", 16'h00C3, {8'h00, rsp.rdata[7:0]});
    xfer(0, 21'h00100, 16'h0000, 2'b00);
    cmp16("even byte", 16'h003C, {8'h00, rsp.rdata[7:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    {rst_n, req_valid, req, err_key, lat} = '0;
    {fail_count, checked, cyc} = '0;
    do_reset(1'b1);
    t_wide();
    t_lanes();
    t_err();
    t_nolane();
    t_narrow();
    cmp16("pin faults", 16'h0000, 16'(viol));
    summarize();
  end
endmodule

// ### pkg/sram_host_pkg.sv
// package for the static memory host controller: pin groups, commands, timing
package sram_host_pkg;

  localparam int ADDR_W = 21;  // 20 word bits plus low byte bit in 8-bit mode
  localparam int DATA_W = 16;

  // timing in ns for the faster speed grade
  localparam int CLK_PERIOD_NS   = 4;
  localparam int T_RC_NS         = 45;  // read cycle time
  localparam int T_AA_NS         = 45;  // address to data valid
  localparam int T_WC_NS         = 45;  // write cycle time
  localparam int T_PWE_NS        = 35;  // strobe low pulse
  localparam int T_HZWE_NS       = 18;  // strobe_to_float_delay
  localparam int T_SD_NS         = 25;  // data_setup_to_end
  localparam int T_HD_NS         = 0;   // data hold after write end
  localparam int T_HZOE_NS       = 18;  // output enable high to float

  // least times round up to whole cycles
  localparam int RD_CYC   = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLT_CYC  = (T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_CYC   = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWE_MIN  = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWE_CYC  = (FLT_CYC + SD_CYC > PWE_MIN) ? FLT_CYC + SD_CYC : PWE_MIN;
  localparam int HZOE_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC   = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_CYC   = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int CNT_W    = 6;

  // user request
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lane_en;  // bit1 upper, bit0 lower, active high
  } req_s;

  // user answer
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              corrected;
  } rsp_s;

  // control pins toward the memory
  typedef struct packed {
    logic first_select_n;
    logic second_select_high;
    logic write_strobe_n;
    logic output_enable_n;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
  } ctl_s;

  localparam ctl_s CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ### src/sram_host.sv
// host controller driving an asynchronous static memory with error flag
`timescale 1ns/1ps
module sram_host #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W,
  parameter int DATA_W = sram_host_pkg::DATA_W
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      wide_mode,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire sram_host_pkg::req_s       req,
  output logic                           rsp_valid,
  output sram_host_pkg::rsp_s            rsp,
  output logic [19:0]                    mem_addr,
  output logic                           mem_byte_addr,
  output sram_host_pkg::ctl_s            mem_ctl,
  input  wire logic [DATA_W-1:0]         mem_data_in,
  output logic [DATA_W-1:0]              mem_data_out,
  output logic [1:0]                     mem_data_oe,
  input  wire logic                      mem_err_in
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RSET  = 3'b001,
    ST_READ  = 3'b010,
    ST_WSET  = 3'b011,
    ST_WLOW  = 3'b100,
    ST_WHOLD = 3'b101,
    ST_GAP   = 3'b110
  } state_e;

  localparam logic [5:0] RD_N   = 6'(sram_host_pkg::RD_CYC);
  localparam logic [5:0] PWE_N  = 6'(sram_host_pkg::PWE_CYC);
  localparam logic [5:0] FLT_N  = 6'(sram_host_pkg::FLT_CYC);
  localparam logic [5:0] HOLD_N = 6'(sram_host_pkg::HOLD_CYC);
  localparam logic [5:0] GAP_N  = 6'(sram_host_pkg::HZOE_CYC);

  state_e                   state_r, state_nxt;
  logic [5:0]               cnt_r, cnt_nxt;
  sram_host_pkg::req_s      req_r, req_nxt;
  sram_host_pkg::ctl_s      ctl_r, ctl_nxt;
  logic [1:0]               oe_r, oe_nxt;
  logic                     rv_r, rv_nxt;
  sram_host_pkg::rsp_s      rsp_r, rsp_nxt;
  logic [1:0]               ln_r;

  // lane enables for the current request, active high
  function automatic logic [1:0] lanes(input sram_host_pkg::req_s r, input logic wide);
    if (wide) begin
      lanes = r.lane_en;
    end else begin
      lanes = 2'b01;
    end
  endfunction

  // lanes of the latched request, indexed bit by bit below
  assign ln_r = lanes(req_r, wide_mode);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    req_nxt   = req_r;
    ctl_nxt   = ctl_r;
    oe_nxt    = oe_r;
    rv_nxt    = 1'b0;
    rsp_nxt   = rsp_r;
    case (state_r)
      ST_IDLE: begin
        ctl_nxt = sram_host_pkg::CTL_IDLE;
        if (req_valid && lanes(req, wide_mode) != 2'b00) begin
          req_nxt = req;
          cnt_nxt = '0;
          // address goes out one cycle before selects rise
          state_nxt = req.write ? ST_WSET : ST_RSET;
        end
      end
      ST_RSET: begin
        ctl_nxt.first_select_n      = 1'b0;
        ctl_nxt.second_select_high  = 1'b1;
        ctl_nxt.write_strobe_n      = 1'b1;
        ctl_nxt.output_enable_n     = 1'b0;
        ctl_nxt.upper_lane_enable_n = ~ln_r[1];
        ctl_nxt.lower_lane_enable_n = ~ln_r[0];
        cnt_nxt   = '0;
        state_nxt = ST_READ;
      end
      ST_READ: begin
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == RD_N) begin
          // data and flag sampled together after access time
          rsp_nxt.rdata     = mem_data_in;
          rsp_nxt.corrected = mem_err_in;
          if (!ln_r[1]) begin
            rsp_nxt.rdata[15:8] = 8'h00;
          end
          if (!ln_r[0]) begin
            rsp_nxt.rdata[7:0] = 8'h00;
          end
          rv_nxt    = 1'b1;
          ctl_nxt   = sram_host_pkg::CTL_IDLE;
          cnt_nxt   = '0;
          state_nxt = ST_GAP;
        end
      end
      ST_WSET: begin
        ctl_nxt.first_select_n      = 1'b0;
        ctl_nxt.second_select_high  = 1'b1;
        ctl_nxt.output_enable_n     = 1'b1;
        ctl_nxt.upper_lane_enable_n = ~ln_r[1];
        ctl_nxt.lower_lane_enable_n = ~ln_r[0];
        ctl_nxt.write_strobe_n      = 1'b0;
        cnt_nxt   = '0;
        state_nxt = ST_WLOW;
      end
      ST_WLOW: begin
        cnt_nxt = cnt_r + 6'h01;
        // drive data only after the memory's outputs have floated
        if (cnt_r + 6'h01 == FLT_N) begin
          oe_nxt = lanes(req_r, wide_mode);
        end
        if (cnt_r + 6'h01 == PWE_N) begin
          ctl_nxt.write_strobe_n = 1'b1;
          cnt_nxt   = '0;
          state_nxt = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        // data held past the strobe edge that ends the write
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r + 6'h01 == HOLD_N) begin
          oe_nxt    = 2'b00;
          ctl_nxt   = sram_host_pkg::CTL_IDLE;
          cnt_nxt   = '0;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        // recovery so the memory floats before the next access
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r + 6'h01 == GAP_N) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ctl_nxt   = sram_host_pkg::CTL_IDLE;
        oe_nxt    = 2'b00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      req_r   <= '0;
      ctl_r   <= sram_host_pkg::CTL_IDLE;
      oe_r    <= 2'b00;
      rv_r    <= 1'b0;
      rsp_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      req_r   <= req_nxt;
      ctl_r   <= ctl_nxt;
      oe_r    <= oe_nxt;
      rv_r    <= rv_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin and user outputs
  assign req_ready     = (state_r == ST_IDLE);
  assign rsp_valid     = rv_r;
  assign rsp           = rsp_r;
  assign mem_ctl       = ctl_r;
  assign mem_addr      = wide_mode ? req_r.addr[19:0] : req_r.addr[20:1];
  assign mem_byte_addr = wide_mode ? 1'b0 : req_r.addr[0];
  assign mem_data_out  = req_r.wdata;
  assign mem_data_oe   = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_strobe_high_read;
    @(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_READ) |-> mem_ctl.write_strobe_n;
  endproperty
  a_strobe_high_read: assert property (p_strobe_high_read) else $error("strobe low in read");

  property p_no_drive_while_oe;
    @(posedge core_clk) disable iff (!rst_n)
      (mem_data_oe != 2'b00) |-> (mem_ctl.output_enable_n && !mem_ctl.write_strobe_n || state_r == ST_WHOLD);
  endproperty
  a_no_drive_while_oe: assert property (p_no_drive_while_oe) else $error("data driven against memory");

  property p_pulse_width;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(mem_ctl.write_strobe_n) |-> !mem_ctl.write_strobe_n [*8] ##1 !mem_ctl.write_strobe_n [*4];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("strobe pulse too short");

  property p_data_hold;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(mem_ctl.write_strobe_n) |-> (mem_data_oe != 2'b00);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data dropped at write end");

  property p_addr_before_select;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(mem_ctl.first_select_n) |-> $stable(mem_addr);
  endproperty
  a_addr_before_select: assert property (p_addr_before_select) else $error("address moved at select");

  property p_write_qualified;
    @(posedge core_clk) disable iff (!rst_n)
      !mem_ctl.write_strobe_n |-> (!mem_ctl.first_select_n && mem_ctl.second_select_high &&
        !(mem_ctl.upper_lane_enable_n && mem_ctl.lower_lane_enable_n));
  endproperty
  a_write_qualified: assert property (p_write_qualified) else $error("strobe without qualifiers");

  property p_narrow_lane;
    @(posedge core_clk) disable iff (!rst_n)
      (!wide_mode && state_r == ST_WLOW) |-> (mem_ctl.upper_lane_enable_n && mem_data_oe[1] == 1'b0);
  endproperty
  a_narrow_lane: assert property (p_narrow_lane) else $error("upper lane used in narrow mode");

  property p_read_answer;
    @(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_RSET) |-> ##14 rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

endmodule
